// >>> hbms_top.sv
/*
 * H-bridge mode controller with 16-bit SPI slave, operating modes,
 * wake/power-down sequencing of the fault flag and bridge leg control.
 * Assumes SCLK, CS_N, MOSI, pins and analog sense levels are
 * asynchronous; supply and current comparators live outside.
 */
// Overview of operation
// - frame is 16 clocks, MSB first
// - sample MOSI on fall, drive MISO on rise
// - excess bits shift out on MISO
// - zero or non-multiple-of-16 clocks: framing error
// - MISO carries previously selected register
// - first frame after wake returns status
// - read command ignores data bits
// - fixed-mode slave, SCLK at most 10 MHz
// - sleep disables all but the flag and CUR_LIMIT_HALF
// - standby: logic alive, legs high impedance
// - normal mode; fault moves to fault mode
// - fault mode: legs off, flag latched low
// - wake high with supply starts power-up
// - power-up flag pulse, release on pump ok
// - flag high within 1 ms of wake
// - wake low: legs off, delayed power-down
// - flag released in sleep only with kill low
// - flag held until supplies off
// - thermal warning halves current limit
// - short shuts down, limit chops high side
// - legs from pins or SPI soft bits
// - bit 15 write, bits 14:13 select
// - write to register 0 is framing error
// - write one clears inactive status bits
`timescale 1ns/10ps
module hbms_top #(
	parameter int         TURN_ON_CYC = hbms_pkg::TURN_ON_CYC,
	parameter int         TMR_W       = 17,
	parameter logic [3:0] ID_RSV      = 4'h0  // arbitrary value
) (
	// clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        SYS_RST,
	// spi
	input  wire logic        SCLK,
	input  wire logic        CS_N,
	input  wire logic        MOSI,
	output logic             MISO,
	output logic             MISO_OE,
	// control pins
	input  wire logic        DRIVE_INPUT_A,
	input  wire logic        DRIVE_INPUT_B,
	input  wire logic        WAKE_CONTROL_PIN,
	input  wire logic        OUTPUT_KILL_PIN,
	output logic             FAULT_FLAG_N,
	// analog sense
	input  wire logic        SUPPLY_ABOVE_MIN,
	input  wire logic        CHARGE_PUMP_OK,
	input  wire logic [10:0] DIAG_SENSE,
	// power stage control
	output logic             SUPPLY_ENABLE,
	output logic             BRIDGE_LEG_A_HIGH,
	output logic             BRIDGE_LEG_A_LOW,
	output logic             BRIDGE_LEG_B_HIGH,
	output logic             BRIDGE_LEG_B_LOW,
	output logic       [2:0] SLEW_SEL,
	output logic       [1:0] CUR_LIMIT_SEL,
	output logic             CUR_LIMIT_HALF,
	output logic             HALF_BRIDGE_MODE
);
	localparam int SYN_W = 9 + hbms_pkg::SENSE_W;

	if (TURN_ON_CYC <= hbms_pkg::PO_CYC || TURN_ON_CYC >= 2 ** TMR_W
	    || hbms_pkg::PD_DLY_CYC >= 2 ** TMR_W)
	begin : g_bad_timer
		$error("hbms_top: TURN_ON_CYC out of range for TMR_W");
	end
	if (hbms_pkg::SCLK_HALF_NS < 3 * hbms_pkg::CLK_PERIOD_NS)
	begin : g_bad_sclk
		$error("hbms_top: clock too slow to sample SCLK");
	end

	// ==========================================================
	// input synchronisation
	logic [SYN_W-1:0] syn;
	logic             sclk_s, cs_s, mosi_s, wake_s, kill_s;
	logic             ina_s, inb_s, vpwr_s, cp_s;
	logic [10:0]      sense_s;
	logic [3:0]       prev;

	hbms_sync #(
		.WIDTH   (SYN_W),
		.RST_VAL ({1'b0, 1'b1, 7'h00, 11'h000})
	) u_sync (
		.clk (CLK_SYS),
		.rst (SYS_RST),
		.d   ({SCLK, CS_N, MOSI, WAKE_CONTROL_PIN, OUTPUT_KILL_PIN,
		       DRIVE_INPUT_A, DRIVE_INPUT_B, SUPPLY_ABOVE_MIN,
		       CHARGE_PUMP_OK, DIAG_SENSE}),
		.q   (syn)
	);
	assign {sclk_s, cs_s, mosi_s, wake_s, kill_s, ina_s, inb_s, vpwr_s,
	        cp_s, sense_s} = syn;

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			prev <= 4'h4;
		else
			prev <= {sclk_s, cs_s, wake_s, kill_s};
	end

	hbms_pkg::hbms_state_e state, next_state;
	logic spi_on, sclk_rise, sclk_fall, cs_fall, cs_rise;
	logic wake_rise, kill_fall;
	assign spi_on    = state != hbms_pkg::ST_SLEEP;
	assign sclk_rise = sclk_s & ~prev[3];
	assign sclk_fall = ~sclk_s & prev[3];
	assign cs_fall   = spi_on & ~cs_s & prev[2];
	assign cs_rise   = spi_on & cs_s & ~prev[2];
	assign wake_rise = wake_s & ~prev[1];
	assign kill_fall = ~kill_s & prev[0];

	// ==========================================================
	// spi shifter
	logic [15:0] sr, next_sr, tx_word, status_word;
	logic        miso_q, next_miso;
	logic [3:0]  bit_cnt, next_bit_cnt;
	logic        clk_seen, next_clk_seen, first, next_first;
	hbms_pkg::hbms_sel_e sel, next_sel, cmd_sel;
	logic [12:0] mask, next_mask, cfg, next_cfg;
	logic [11:0] status, next_status;
	logic        frame_ok, cmd_wr, wr_id, frm_evt, cmd_ok;

	assign cmd_wr   = sr[hbms_pkg::WR_BIT];
	assign cmd_sel  = hbms_pkg::hbms_sel_e'(sr[hbms_pkg::SEL_HI:hbms_pkg::SEL_LO]);
	assign frame_ok = clk_seen && bit_cnt == 4'h0;
	assign wr_id    = cmd_wr && cmd_sel == hbms_pkg::SEL_ID;
	assign frm_evt  = cs_rise && (!frame_ok || wr_id);
	assign cmd_ok   = cs_rise && frame_ok && !wr_id;
	assign status_word = {3'h1, 1'b0, status};

	always_comb begin
		unique case (first ? hbms_pkg::SEL_STATUS : sel)
			hbms_pkg::SEL_ID:     tx_word = {3'h0, hbms_pkg::ID_BASE | {9'h000, ID_RSV}};
			hbms_pkg::SEL_STATUS: tx_word = status_word;
			hbms_pkg::SEL_MASK:   tx_word = {3'h2, mask};
			hbms_pkg::SEL_CONFIG: tx_word = {3'h3, cfg};
		endcase
	end

	always_comb begin
		next_sr       = sr;
		next_miso     = miso_q;
		next_bit_cnt  = bit_cnt;
		next_clk_seen = clk_seen;
		next_first    = first;
		next_sel      = sel;
		if (state == hbms_pkg::ST_SLEEP && next_state == hbms_pkg::ST_PWRUP)
			next_first = 1'b1;
		if (cs_fall) begin
			next_sr       = tx_word;
			next_miso     = tx_word[15];
			next_bit_cnt  = 4'h0;
			next_clk_seen = 1'b0;
			next_first    = 1'b0;
		end else if (spi_on && !cs_s) begin
			if (sclk_fall) begin
				next_sr       = {sr[14:0], mosi_s};
				next_bit_cnt  = 4'(bit_cnt + 4'h1);
				next_clk_seen = 1'b1;
			end
			if (sclk_rise)
				next_miso = sr[15];
		end
		if (cmd_ok)
			next_sel = cmd_sel;
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			sr       <= 16'h0000;
			miso_q   <= 1'b0;
			bit_cnt  <= 4'h0;
			clk_seen <= 1'b0;
			first    <= 1'b1;
			sel      <= hbms_pkg::SEL_STATUS;
		end else begin
			sr       <= next_sr;
			miso_q   <= next_miso;
			bit_cnt  <= next_bit_cnt;
			clk_seen <= next_clk_seen;
			first    <= next_first;
			sel      <= next_sel;
		end
	end

	assign MISO    = miso_q;
	assign MISO_OE = spi_on & ~cs_s;

	// ==========================================================
	// registers
	logic [11:0] clr, eff_mask;
	logic        fault_any;

	always_comb begin
		clr = 12'h000;
		if (cmd_ok && cmd_wr && cmd_sel == hbms_pkg::SEL_STATUS)
			clr = sr[11:0];
		if (wake_rise || kill_fall)
			clr = 12'hfff;
		// set wins: a still-present fault survives its clear
		next_status = (status & ~clr) | {frm_evt, sense_s};
		next_mask   = mask;
		next_cfg    = cfg;
		if (cmd_ok && cmd_wr && cmd_sel == hbms_pkg::SEL_MASK)
			next_mask = sr[12:0];
		if (cmd_ok && cmd_wr && cmd_sel == hbms_pkg::SEL_CONFIG)
			next_cfg = sr[12:0];
		if (state == hbms_pkg::ST_SLEEP) begin
			next_status = 12'h000;
			next_mask   = hbms_pkg::MASK_RST;
			next_cfg    = hbms_pkg::CFG_RST;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			status <= 12'h000;
			mask   <= hbms_pkg::MASK_RST;
			cfg    <= hbms_pkg::CFG_RST;
		end else begin
			status <= next_status;
			mask   <= next_mask;
			cfg    <= next_cfg;
		end
	end

	always_comb begin
		eff_mask = mask[11:0];
		if (mask[hbms_pkg::MSK_DOV])
			eff_mask[hbms_pkg::ST_OV] = 1'b0;
	end
	assign fault_any = |(status & eff_mask);

	// ==========================================================
	// operating mode
	logic [TMR_W-1:0] elapsed;
	logic             out_en, flag_n, next_flag_n;

	hbms_tmr #(
		.WIDTH (TMR_W)
	) u_tmr (
		.clk     (CLK_SYS),
		.rst     (SYS_RST),
		.restart (next_state != state),
		.count   (elapsed)
	);

	assign out_en = cfg[hbms_pkg::CFG_EN] & ~kill_s;

	always_comb begin
		next_state = state;
		unique case (state)
			hbms_pkg::ST_SLEEP:
				if (wake_s && vpwr_s)
					next_state = hbms_pkg::ST_PWRUP;
			hbms_pkg::ST_PWRUP:
				if (!wake_s)
					next_state = hbms_pkg::ST_PWRDN;
				else if (elapsed >= TMR_W'(hbms_pkg::PO_CYC - 1) && cp_s && !fault_any)
					next_state = hbms_pkg::ST_STANDBY;
				else if (elapsed >= TMR_W'(TURN_ON_CYC - 1))
					next_state = hbms_pkg::ST_FAULT;
			hbms_pkg::ST_STANDBY:
				if (!wake_s)
					next_state = hbms_pkg::ST_PWRDN;
				else if (fault_any)
					next_state = hbms_pkg::ST_FAULT;
				else if (out_en)
					next_state = hbms_pkg::ST_NORMAL;
			hbms_pkg::ST_NORMAL:
				if (!wake_s)
					next_state = hbms_pkg::ST_PWRDN;
				else if (fault_any)
					next_state = hbms_pkg::ST_FAULT;
				else if (!out_en)
					next_state = hbms_pkg::ST_STANDBY;
			hbms_pkg::ST_FAULT:
				if (!wake_s)
					next_state = hbms_pkg::ST_PWRDN;
				else if (!fault_any)
					next_state = hbms_pkg::ST_STANDBY;
			hbms_pkg::ST_PWRDN:
				if (elapsed >= TMR_W'(hbms_pkg::PD_DLY_CYC - 1))
					next_state = hbms_pkg::ST_SLEEP;
			default:
				next_state = hbms_pkg::ST_SLEEP;
		endcase
	end

	always_comb begin
		unique case (next_state)
			hbms_pkg::ST_STANDBY, hbms_pkg::ST_NORMAL:
				next_flag_n = 1'b1;
			hbms_pkg::ST_SLEEP:
				next_flag_n = ~kill_s;
			default:
				next_flag_n = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			state  <= hbms_pkg::ST_SLEEP;
			flag_n <= 1'b0;
		end else begin
			state  <= next_state;
			flag_n <= next_flag_n;
		end
	end

	assign FAULT_FLAG_N = flag_n;

	// ==========================================================
	// bridge control
	logic       drv_on, cmd_a, cmd_b, short_s, chop;
	logic [5:0] pst, next_pst;

	assign short_s = |sense_s[hbms_pkg::ST_SHORT +: 4];
	assign chop    = sense_s[hbms_pkg::ST_OC];
	assign drv_on  = next_state == hbms_pkg::ST_NORMAL && !short_s;
	assign cmd_a   = cfg[hbms_pkg::CFG_INPUT] ? cfg[hbms_pkg::CFG_SOFT_DRIVE_A] : ina_s;
	assign cmd_b   = cfg[hbms_pkg::CFG_INPUT] ? cfg[hbms_pkg::CFG_SOFT_DRIVE_B] : inb_s;

	always_comb begin
		next_pst[0] = drv_on & cmd_a & ~chop;
		next_pst[1] = drv_on & ~cmd_a;
		next_pst[2] = drv_on & cmd_b & ~chop;
		next_pst[3] = drv_on & ~cmd_b;
		next_pst[4] = sense_s[hbms_pkg::ST_TW];
		next_pst[5] = next_state != hbms_pkg::ST_SLEEP;
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			pst <= 6'h00;
		else
			pst <= next_pst;
	end

	assign {SUPPLY_ENABLE, CUR_LIMIT_HALF, BRIDGE_LEG_B_LOW,
	        BRIDGE_LEG_B_HIGH, BRIDGE_LEG_A_LOW, BRIDGE_LEG_A_HIGH} = pst;
	assign SLEW_SEL         = cfg[hbms_pkg::CFG_SR +: 3];
	assign CUR_LIMIT_SEL    = cfg[hbms_pkg::CFG_ILM +: 2];
	assign HALF_BRIDGE_MODE = ~cfg[hbms_pkg::CFG_MODE];

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);

	chk_frame_count: assert property (
		cs_rise && !frame_ok |=> status[hbms_pkg::ST_FRM])
		else $error("bad clock count did not flag framing error");
	chk_write_id: assert property (
		cs_rise && frame_ok && wr_id |=> status[hbms_pkg::ST_FRM] && sel == $past(sel))
		else $error("write to register 0 not flagged");
	chk_first_status: assert property (
		cs_fall && first |=> sr == $past(status_word) && miso_q == $past(status_word[15]))
		else $error("first frame after wake did not return status");
	chk_prev_sel: assert property (
		cmd_ok |=> sel == $past(cmd_sel) ##1 (!cs_fall || !first) [*1])
		else $error("selected register not remembered");
	chk_shift_in: assert property (
		spi_on && !cs_s && sclk_fall && !cs_fall
		|=> sr == {$past(sr[14:0]), $past(mosi_s)})
		else $error("MOSI not shifted on falling edge");
	chk_daisy_out: assert property (
		spi_on && !cs_s && sclk_rise && !cs_fall |=> MISO == $past(sr[15]))
		else $error("MISO not updated from shift register");
	chk_pwrup_pulse: assert property (
		state == hbms_pkg::ST_PWRUP && next_state == hbms_pkg::ST_STANDBY
		|-> elapsed >= TMR_W'(hbms_pkg::PO_CYC - 1) && cp_s && !FAULT_FLAG_N)
		else $error("power-up flag released early");
	chk_pd_delay: assert property (
		state == hbms_pkg::ST_PWRDN && next_state == hbms_pkg::ST_SLEEP
		|-> elapsed == TMR_W'(hbms_pkg::PD_DLY_CYC - 1))
		else $error("power-down delay wrong");
	chk_pd_flag: assert property (
		state == hbms_pkg::ST_PWRDN |-> !FAULT_FLAG_N && !(|pst[3:0]))
		else $error("flag or legs active during power-down");
	chk_fault_latch: assert property (
		state == hbms_pkg::ST_FAULT |-> !FAULT_FLAG_N && !(|pst[3:0]))
		else $error("fault mode leaves flag high or legs on");
	chk_standby_hiz: assert property (
		state == hbms_pkg::ST_STANDBY |-> !(|pst[3:0]))
		else $error("leg driven in standby");
	chk_kill_flag: assert property (
		state == hbms_pkg::ST_SLEEP && $past(state) == hbms_pkg::ST_SLEEP
		&& $past(kill_s) |-> !FAULT_FLAG_N)
		else $error("flag released while kill high");
	chk_half_limit: assert property (
		sense_s[hbms_pkg::ST_TW] && next_state != hbms_pkg::ST_SLEEP
		|=> CUR_LIMIT_HALF ##0 status[hbms_pkg::ST_TW])
		else $error("thermal warning not applied");
	chk_short_off: assert property (
		short_s |=> !(|pst[3:0]))
		else $error("legs on during short");

	cov_cfg_write: cover property (
		cmd_ok && cmd_wr && cmd_sel == hbms_pkg::SEL_CONFIG);
	cov_frame_err: cover property (frm_evt);
	cov_wake_up: cover property (
		state == hbms_pkg::ST_PWRUP ##1 state == hbms_pkg::ST_STANDBY);
	cov_fault: cover property (
		state == hbms_pkg::ST_NORMAL ##1 state == hbms_pkg::ST_FAULT);
endmodule

// >>> hbms_pkg.sv
/*
 * Shared constants for the H-bridge mode controller and SPI slave:
 * command word layout, register selects, field positions, reset values,
 * operating states and timing figures.
 * Assumes a 100 MHz system clock.
 */
package hbms_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SPI_MAX_HZ     = 10_000_000;
	localparam int SCLK_HALF_NS   = 1_000_000_000 / SPI_MAX_HZ / 2;
	localparam int PO_MIN_NS      = 1000;
	localparam int PO_MAX_NS      = 2000;
	localparam int PD_DLY_MIN_NS  = 8000;
	localparam int PD_DLY_MAX_NS  = 11000;
	localparam int TURN_ON_MAX_NS = 1_000_000;
	localparam int PO_CYC         = (PO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PD_DLY_CYC     = (PD_DLY_MIN_NS + CLK_PERIOD_NS - 1)
	                                / CLK_PERIOD_NS;
	localparam int TURN_ON_CYC    = TURN_ON_MAX_NS / CLK_PERIOD_NS;

	// ==========================================================
	// command word
	localparam int WORD_BITS = 16;
	localparam int DATA_BITS = 13;
	localparam int WR_BIT    = 15;
	localparam int SEL_HI    = 14;
	localparam int SEL_LO    = 13;

	typedef enum logic [1:0] {
		SEL_ID     = 2'h0,
		SEL_STATUS = 2'h1,
		SEL_MASK   = 2'h2,
		SEL_CONFIG = 2'h3
	} hbms_sel_e;

	// ==========================================================
	// status and mask fields
	localparam int ST_FRM   = 11;
	localparam int ST_OV    = 8;
	localparam int ST_SHORT = 4;
	localparam int ST_OC    = 2;
	localparam int ST_TW    = 1;
	localparam int MSK_DOV  = 12;
	localparam int SENSE_W  = 11;

	// ==========================================================
	// configuration fields
	localparam int CFG_SOFT_DRIVE_A  = 0;
	localparam int CFG_SOFT_DRIVE_B  = 1;
	localparam int CFG_INPUT = 2;
	localparam int CFG_MODE  = 3;
	localparam int CFG_EN    = 4;
	localparam int CFG_SR    = 5;
	localparam int CFG_ILM   = 8;

	// ==========================================================
	// reset values
	localparam logic [12:0] MASK_RST = 13'h06f1;
	localparam logic [12:0] CFG_RST  = 13'h0d98;
	localparam logic [12:0] ID_BASE  = 13'h0010;

	// ==========================================================
	// operating states
	typedef enum logic [5:0] {
		ST_SLEEP   = 6'h01,
		ST_PWRUP   = 6'h02,
		ST_STANDBY = 6'h04,
		ST_NORMAL  = 6'h08,
		ST_FAULT   = 6'h10,
		ST_PWRDN   = 6'h20
	} hbms_state_e;

endpackage

// >>> hbms_sync.sv
/*
 * Two-flop synchroniser for a vector of asynchronous levels.
 * Assumes each bit is an independent level; no bus coherency.
 */
`timescale 1ns/10ps
module hbms_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// levels
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	if (WIDTH < 1) begin : g_bad_width
		$error("hbms_sync: WIDTH must be at least 1");
	end

	// ==========================================================
	// stages
	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= RST_VAL;
			q    <= RST_VAL;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// >>> hbms_tmr.sv
/*
 * Saturating elapsed-cycle counter, cleared by a restart pulse.
 * Assumes restart comes from logic on the same clock.
 */
`timescale 1ns/10ps
module hbms_tmr #(
	parameter int WIDTH = 17
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// control
	input  wire logic             restart,
	output logic      [WIDTH-1:0] count
);
	logic [WIDTH-1:0] next_count;

	if (WIDTH < 2) begin : g_bad_width
		$error("hbms_tmr: WIDTH must be at least 2");
	end

	// ==========================================================
	// counter
	always_comb begin
		if (restart)
			next_count = '0;
		else if (&count)
			next_count = count;
		else
			next_count = count + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst)
			count <= '0;
		else
			count <= next_count;
	end
endmodule

// >>> hbms_host_model.sv
/*
 * Host-side SPI master model for the H-bridge mode controller.
 * Assumes the system clock paces every SCLK edge; SCLK period 80 ns.
 */
`timescale 1ns/10ps
module hbms_host_model (
	// clock
	input  wire logic clk,
	// spi
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso,
	input  wire logic miso_oe
);
	logic miso_last;
	logic miso_w;

	initial begin
		sclk      = 1'b0;
		cs_n      = 1'b1;
		mosi      = 1'b0;
		miso_last = 1'b0;
	end

	always @(posedge clk) begin
		if (miso_oe === 1'b1) begin
			miso_last <= miso;
		end
	end

	// released line shows the inverse of its last level
	assign miso_w = (miso_oe === 1'b1) ? miso : ~miso_last;

	// ==========================================================
	// one frame of nbits clocks, msb first
	task automatic frame(input logic [31:0] tx, input int nbits,
		output logic [31:0] rx);
		int i;
		rx = '0;
		@(negedge clk);
		cs_n = 1'b0;
		repeat (10) @(negedge clk);
		for (i = nbits - 1; i >= 0; i--) begin
			sclk  = 1'b1;
			mosi  = tx[i];
			repeat (4) @(negedge clk);
			// master takes MISO at the falling edge
			rx[i] = miso_w;
			sclk = 1'b0;
			repeat (4) @(negedge clk);
		end
		repeat (2) @(negedge clk);
		cs_n = 1'b1;
		mosi = 1'b0;
		repeat (40) @(negedge clk);
	endtask
endmodule

// >>> hbms_top_tb.sv
/*
 * Self-checking bench for the H-bridge mode controller.
 * Assumes the host model drives the spi pins; pins change at clk fall.
 */
`timescale 1ns/10ps
module hbms_top_tb;
	localparam int TON = 300;

	logic        clk;
	logic        rst;
	logic        sclk;
	logic        cs_n;
	logic        mosi;
	logic        miso;
	logic        miso_oe;
	logic        in_a;
	logic        in_b;
	logic        wake;
	logic        kill;
	logic        flag_n;
	logic        supply_ok;
	logic        pump_ok;
	logic [10:0] sense;
	logic        supply_en;
	logic [3:0]  legs;
	logic [2:0]  slew;
	logic [1:0]  cur_sel;
	logic        cur_half;
	logic        half_mode;
	logic [31:0] rx;
	int          n_fail;
	int          checked;
	int          n;
	int          m;
	int          k;
	int          bits [3] = '{15, 0, 16};
	logic [15:0] bad [3] = '{16'h6000, 16'h6000, 16'h8000};

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	hbms_host_model host_inst (
		.clk     (clk),
		.sclk    (sclk),
		.cs_n    (cs_n),
		.mosi    (mosi),
		.miso    (miso),
		.miso_oe (miso_oe)
	);

	hbms_top #(.TURN_ON_CYC(TON), .TMR_W(10), .ID_RSV(4'h0)) hbms_top_inst (
		.CLK_SYS           (clk),
		.SYS_RST           (rst),
		.SCLK              (sclk),
		.CS_N              (cs_n),
		.MOSI              (mosi),
		.MISO              (miso),
		.MISO_OE           (miso_oe),
		.DRIVE_INPUT_A     (in_a),
		.DRIVE_INPUT_B     (in_b),
		.WAKE_CONTROL_PIN  (wake),
		.OUTPUT_KILL_PIN   (kill),
		.FAULT_FLAG_N      (flag_n),
		.SUPPLY_ABOVE_MIN  (supply_ok),
		.CHARGE_PUMP_OK    (pump_ok),
		.DIAG_SENSE        (sense),
		.SUPPLY_ENABLE     (supply_en),
		.BRIDGE_LEG_A_HIGH (legs[3]),
		.BRIDGE_LEG_A_LOW  (legs[2]),
		.BRIDGE_LEG_B_HIGH (legs[1]),
		.BRIDGE_LEG_B_LOW  (legs[0]),
		.SLEW_SEL          (slew),
		.CUR_LIMIT_SEL     (cur_sel),
		.CUR_LIMIT_HALF    (cur_half),
		.HALF_BRIDGE_MODE  (half_mode)
	);

	// ==========================================================
	// tasks
	task automatic cmp(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic close_out();
		$display("checks %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic xfer(input logic [15:0] cmd, input logic [15:0] exp);
		host_inst.frame({16'h0, cmd}, 16, rx);
		cmp("miso word", {16'h0, exp}, rx);
	endtask

	task automatic wait_flag(input logic v, output int cyc);
		cyc = 0;
		while (flag_n !== v) begin
			@(negedge clk);
			cyc++;
			if (cyc > 3000) begin
				n_fail++;
				$display("unexpected flag wait: expected %b, seen %b", v, flag_n);
				close_out();
			end
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		n_fail = 0;
		checked = 0;
		rst = 1'b1;
		{in_a, in_b, wake, kill, supply_ok, pump_ok} = 6'b10_0101;
		sense = '0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (5) @(negedge clk);
		cmp("sleep flag", 32'h0, {31'h0, flag_n});
		cmp("sleep outs", 32'h0, {26'h0, supply_en, miso_oe, legs});
		kill = 1'b0;
		wake = 1'b1;
		repeat (20) @(negedge clk);
		cmp("no supply", 32'h0, {31'h0, supply_en});
		supply_ok = 1'b1;
		wait_flag(1'b0, n);
		wait_flag(1'b1, m);
		cmp("pulse min", 32'h1, {31'h0, m >= hbms_pkg::PO_CYC});
		cmp("pulse max", 32'h1, {31'h0, m <= 200});
		cmp("turn on", 32'h1, {31'h0, n + m <= TON});
		repeat (10) @(negedge clk);
		cmp("normal legs", 32'h9, {28'h0, legs});
		kill = 1'b1;
		repeat (6) @(negedge clk);
		cmp("standby legs", 32'h0, {28'h0, legs});
		kill = 1'b0;
		$display("test wake done");
		xfer(16'h6000, 16'h2000);
		xfer(16'h7fff, 16'h6d98);
		xfer(16'h6000, 16'h6d98);
		host_inst.frame(32'h2000, 16, rx);
		for (k = 0; k < 3; k++) begin
			host_inst.frame({16'h0, bad[k]}, bits[k], rx);
			host_inst.frame(32'h2000, 16, rx);
			xfer(16'h2000, 16'h2800);
			xfer(16'ha800, 16'h2800);
			xfer(16'h2000, 16'h2000);
		end
		host_inst.frame(32'ha5a5_6000, 32, rx);
		cmp("chain out", 32'h2000_a5a5, rx);
		xfer(16'h6000, 16'h6d98);
		$display("test spi done");
		xfer(16'hed7e, 16'h6d98);
		xfer(16'h6000, 16'h6d7e);
		cmp("soft legs", 32'h6, {28'h0, legs});
		cmp("cfg outs", 32'h0d, {27'h0, slew, cur_sel});
		sense[1] = 1'b1;
		repeat (10) @(negedge clk);
		cmp("half limit", 32'h1, {31'h0, cur_half});
		xfer(16'ha002, 16'h6d7e);
		xfer(16'h2000, 16'h2002);
		sense[0] = 1'b1;
		repeat (10) @(negedge clk);
		cmp("fault outs", 32'h0, {27'h0, flag_n, legs});
		sense[0] = 1'b0;
		xfer(16'ha001, 16'h2003);
		repeat (10) @(negedge clk);
		cmp("recover", 32'h16, {27'h0, flag_n, legs});
		$display("test fault done");
		wake = 1'b0;
		repeat (5) @(negedge clk);
		cmp("pd outs", 32'h0, {27'h0, flag_n, legs});
		wait_flag(1'b1, n);
		cmp("pd delay", 32'h1, {31'h0, n + 5 >= 800 && n + 5 <= 1100});
		cmp("pd supply", 32'h0, {31'h0, supply_en});
		kill = 1'b1;
		repeat (5) @(negedge clk);
		cmp("kill flag", 32'h0, {31'h0, flag_n});
		$display("test power down done");
		close_out();
	end
endmodule
